// file: verilog/sbt_top.sv
`timescale 1ns/1ps
`include "sbt_defs.svh"

module sbt_top (
  input  wire logic        pclk,        // System clock, 200 MHz.
  input  wire logic        presetn,     // Asynchronous reset, active low.
  input  wire logic        psel,        // APB select.
  input  wire logic        penable,     // APB enable.
  input  wire logic        pwrite,      // APB direction.
  input  wire logic [7:0]  paddr,       // APB byte address.
  input  wire logic [31:0] pwdata,      // APB write data.
  output logic      [31:0] prdata,      // APB read data.
  output logic             pready,      // APB ready.
  output logic             pslverr,     // APB error on unmapped address.
  output logic             mem_rd,      // Data memory read strobe.
  output logic      [15:0] mem_addr,    // Data memory word address.
  input  wire logic [15:0] mem_rdata,   // Data memory word, one cycle after the strobe.
  input  wire logic        msg_busy,    // Message output holds the shared buffer.
  output logic             tx_valid,    // Byte waiting for the serialiser.
  output logic      [7:0]  tx_data,     // Byte to serialise.
  input  wire logic        tx_ready,    // Serialiser takes the byte.
  output logic             rx_accept,   // Reception allowed.
  output logic             rx_flush     // Pulse that empties the reception buffer.
);
  import sbt_pkg::*;

  sbt_state_t  state;
  sbt_instr_t  instr;
  sbt_status_t status;
  logic [15:0] port_mode_config;
  logic [15:0] start_code_config;
  logic [15:0] end_code_config;
  logic        error_flag;
  logic [15:0] word_addr;
  logic [15:0] word_data;
  logic [7:0]  bytes_left;
  logic [7:0]  buf_data [0:1];
  logic        buf_wptr;
  logic        buf_rptr;
  logic [1:0]  buf_count;
  logic        buf_in_valid;
  logic        buf_in_ready;
  logic [7:0]  buf_in_data;
  logic        wr_en;
  logic        go;
  logic        use_indirect;
  logic        mode_ok;
  logic        comm_enable_flag;
  logic        shared_busy;
  logic        bad_order;
  logic        bad_count;
  logic        bad_ptr;
  logic        bad_area;
  logic        fault;
  logic [13:0] count_bin;
  logic [13:0] ptr_bin;
  logic [15:0] first_word;
  logic [15:0] last_word;
  logic        upper_first;

  // Converts four BCD digits to binary.
  function automatic logic [13:0] bcd_to_bin(input logic [15:0] v);
    logic [13:0] r;
    r = 14'(v[15:12]) * 14'd1000 + 14'(v[11:8]) * 14'd100 + 14'(v[7:4]) * 14'd10 + 14'(v[3:0]);
    return r;
  endfunction

  // True when any nibble is above nine.
  function automatic logic not_bcd(input logic [15:0] v);
    logic r;
    r = (v[15:12] > 4'h9) || (v[11:8] > 4'h9) || (v[7:4] > 4'h9) || (v[3:0] > 4'h9);
    return r;
  endfunction

  // The APB slave answers at once; writes land on the access edge.
  assign wr_en  = psel && penable && pwrite;
  assign pready = 1'b1;
  assign go     = wr_en && (paddr == `SBT_ADDR_CTRL) && pwdata[`SBT_CTRL_GO];

  // Unmapped addresses answer with an error and read as zero.
  assign pslverr = psel && penable && (paddr > `SBT_ADDR_STATUS || paddr[1:0] != 2'b00);

  // The shared transmit buffer counts as in use while any byte of a block or message is pending.
  assign shared_busy      = msg_busy || (state != SBT_IDLE) || (buf_count != 2'd0);
  assign mode_ok          = (port_mode_config[`SBT_MODE_MSB:`SBT_MODE_LSB] == `SBT_MODE_ASCII_IO);
  assign comm_enable_flag = mode_ok && !shared_busy;
  assign rx_accept        = !(mode_ok && state != SBT_IDLE);

  // Operand checks on the values that the start request sees.
  assign count_bin  = bcd_to_bin(instr.count);
  assign ptr_bin    = bcd_to_bin(instr.src);
  assign bad_order  = (instr.order != `SBT_ORDER_UPPER) && (instr.order != `SBT_ORDER_LOWER);
  assign bad_count  = not_bcd(instr.count) || (count_bin > `SBT_COUNT_MAX);
  // The firing write carries the addressing mode, so the checks must see it in that same cycle.
  assign use_indirect = go ? pwdata[`SBT_CTRL_INDIRECT] : instr.indirect;
  assign bad_ptr    = use_indirect && (not_bcd(instr.src) || ptr_bin >= `SBT_MEM_WORDS);
  assign first_word = use_indirect ? {2'b00, ptr_bin} : instr.src;
  assign last_word  = first_word + 16'(((count_bin + 14'd1) >> 1)) - ((count_bin == 14'd0) ? 16'd0 : `SBT_ONE16);
  assign bad_area   = first_word[`SBT_AREA_MSB:`SBT_AREA_LSB] != last_word[`SBT_AREA_MSB:`SBT_AREA_LSB];
  assign fault      = bad_order || bad_count || bad_ptr || bad_area || !mode_ok || shared_busy;
  assign upper_first = (instr.order == `SBT_ORDER_UPPER);

  // Configuration words written by software.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_mode_config  <= `SBT_WORD_ZERO;
      start_code_config <= `SBT_WORD_ZERO;
      end_code_config   <= `SBT_WORD_ZERO;
    end
    else if (wr_en)
    begin
      if (paddr == `SBT_ADDR_PORT_MODE)
        port_mode_config <= pwdata[15:0];
      if (paddr == `SBT_ADDR_START_CODE)
        start_code_config <= pwdata[15:0];
      if (paddr == `SBT_ADDR_END_CODE)
        end_code_config <= pwdata[15:0];
    end
  end

  // Instruction operands; held while a transfer runs so the checks stay stable.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      instr <= '0;
    else if (wr_en && state == SBT_IDLE)
    begin
      if (paddr == `SBT_ADDR_SRC)
        instr.src <= pwdata[15:0];
      if (paddr == `SBT_ADDR_COUNT)
        instr.count <= pwdata[15:0];
      if (paddr == `SBT_ADDR_ORDER)
        instr.order <= pwdata[15:0];
      if (paddr == `SBT_ADDR_CTRL)
        instr.indirect <= pwdata[`SBT_CTRL_INDIRECT];
    end
  end

  // Sticky error flag; a new error wins over a clear written in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      error_flag <= 1'b0;
    else if (go && pwdata[`SBT_CTRL_COND] && fault)
      error_flag <= 1'b1;
    else if (wr_en && paddr == `SBT_ADDR_STATUS && pwdata[`SBT_STAT_ERROR])
      error_flag <= 1'b0;
  end

  // Transfer sequencer: start code, data bytes, end code, then drain.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state      <= SBT_IDLE;
      word_addr  <= `SBT_WORD_ZERO;
      word_data  <= `SBT_WORD_ZERO;
      bytes_left <= `SBT_BYTE_ZERO;
    end
    else
    begin
      unique case (state)
        SBT_IDLE:
        begin
          // A disabled flag or a failed check leaves the port silent.
          if (go && pwdata[`SBT_CTRL_COND] && comm_enable_flag && !fault)
          begin
            word_addr  <= first_word;
            bytes_left <= count_bin[7:0];
            state      <= SBT_START;
          end
        end
        SBT_START:
        begin
          if (start_code_config[`SBT_CODE_FLAG_MSB:`SBT_CODE_FLAG_LSB] != `SBT_CODE_ON || buf_in_ready)
            state <= (bytes_left == `SBT_BYTE_ZERO) ? SBT_END : SBT_FETCH;
        end
        SBT_FETCH:
          state <= SBT_LOAD;
        SBT_LOAD:
        begin
          word_data <= mem_rdata;
          word_addr <= word_addr + `SBT_ONE16;
          state     <= SBT_FIRST;
        end
        SBT_FIRST:
        begin
          if (buf_in_ready)
          begin
            bytes_left <= bytes_left - `SBT_ONE8;
            state      <= (bytes_left == `SBT_ONE8) ? SBT_END : SBT_SECND;
          end
        end
        SBT_SECND:
        begin
          if (buf_in_ready)
          begin
            bytes_left <= bytes_left - `SBT_ONE8;
            state      <= (bytes_left == `SBT_ONE8) ? SBT_END : SBT_FETCH;
          end
        end
        SBT_END:
        begin
          if (end_code_config[`SBT_CODE_FLAG_MSB:`SBT_CODE_FLAG_LSB] != `SBT_CODE_ON || buf_in_ready)
            state <= SBT_DRAIN;
        end
        SBT_DRAIN:
          if (buf_count == 2'd0)
            state <= SBT_IDLE;
      endcase
    end
  end

  // Byte offered to the buffer in each state, strictly start, data, end.
  always_comb
  begin
    buf_in_valid = 1'b0;
    buf_in_data  = `SBT_BYTE_ZERO;
    unique case (state)
      SBT_START:
      begin
        buf_in_valid = (start_code_config[`SBT_CODE_FLAG_MSB:`SBT_CODE_FLAG_LSB] == `SBT_CODE_ON);
        buf_in_data  = start_code_config[7:0];
      end
      SBT_FIRST:
      begin
        buf_in_valid = 1'b1;
        buf_in_data  = upper_first ? word_data[15:8] : word_data[7:0];
      end
      SBT_SECND:
      begin
        buf_in_valid = 1'b1;
        buf_in_data  = upper_first ? word_data[7:0] : word_data[15:8];
      end
      SBT_END:
      begin
        buf_in_valid = (end_code_config[`SBT_CODE_FLAG_MSB:`SBT_CODE_FLAG_LSB] == `SBT_CODE_ON);
        buf_in_data  = end_code_config[7:0];
      end
      default:
      begin
        buf_in_valid = 1'b0;
      end
    endcase
  end

  // Memory read strobe for the next source word.
  assign mem_rd   = (state == SBT_FETCH);
  assign mem_addr = word_addr;

  // Two-entry buffer; a stalled serialiser holds the sequencer back, so no byte is lost.
  assign buf_in_ready = (buf_count != 2'd2);
  assign tx_valid     = (buf_count != 2'd0);
  assign tx_data      = buf_data[buf_rptr];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buf_data[0] <= `SBT_BYTE_ZERO;
      buf_data[1] <= `SBT_BYTE_ZERO;
      buf_wptr    <= 1'b0;
      buf_rptr    <= 1'b0;
      buf_count   <= 2'd0;
    end
    else
    begin
      if (buf_in_valid && buf_in_ready)
      begin
        buf_data[buf_wptr] <= buf_in_data;
        buf_wptr           <= ~buf_wptr;
      end
      if (tx_valid && tx_ready)
      begin
        buf_rptr <= ~buf_rptr;
      end
      buf_count <= buf_count + 2'(buf_in_valid && buf_in_ready) - 2'(tx_valid && tx_ready);
    end
  end

  // Flush pulse for the reception buffer as the block completes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_flush <= 1'b0;
    else
      rx_flush <= (state == SBT_DRAIN) && (buf_count == 2'd0);
  end

  // Read data is registered so it stands for the whole access phase.
  assign status.enable = comm_enable_flag;
  assign status.error  = error_flag;
  assign status.busy   = (state != SBT_IDLE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        `SBT_ADDR_CTRL:       prdata <= {29'h0, instr.indirect, 2'b00};
        `SBT_ADDR_SRC:        prdata <= {16'h0, instr.src};
        `SBT_ADDR_COUNT:      prdata <= {16'h0, instr.count};
        `SBT_ADDR_ORDER:      prdata <= {16'h0, instr.order};
        `SBT_ADDR_PORT_MODE:  prdata <= {16'h0, port_mode_config};
        `SBT_ADDR_START_CODE: prdata <= {16'h0, start_code_config};
        `SBT_ADDR_END_CODE:   prdata <= {16'h0, end_code_config};
        `SBT_ADDR_STATUS:     prdata <= {29'h0, status};
        default:              prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// file: verilog/sbt_defs.svh
`ifndef SBT_DEFS_SVH
`define SBT_DEFS_SVH

// Register byte addresses on the APB bus.
`define SBT_ADDR_CTRL        8'h00
`define SBT_ADDR_SRC         8'h04
`define SBT_ADDR_COUNT       8'h08
`define SBT_ADDR_ORDER       8'h0c
`define SBT_ADDR_PORT_MODE   8'h10
`define SBT_ADDR_START_CODE  8'h14
`define SBT_ADDR_END_CODE    8'h18
`define SBT_ADDR_STATUS      8'h1c
`define SBT_ADDR_MSB         7

// Control register bits.
`define SBT_CTRL_GO          0
`define SBT_CTRL_COND        1
`define SBT_CTRL_INDIRECT    2

// Status register bits.
`define SBT_STAT_ENABLE      0
`define SBT_STAT_ERROR       1
`define SBT_STAT_BUSY        2

// Field layout of the port mode and code configuration words.
`define SBT_MODE_MSB         11
`define SBT_MODE_LSB         8
`define SBT_MODE_ASCII_IO    4'h2
`define SBT_CODE_FLAG_MSB    15
`define SBT_CODE_FLAG_LSB    8
`define SBT_CODE_ON          8'h01

// Operand limits and encodings.
`define SBT_ORDER_UPPER      16'h0000
`define SBT_ORDER_LOWER      16'h0001
`define SBT_COUNT_MAX        14'd200
`define SBT_MEM_WORDS        14'd2048
`define SBT_AREA_MSB         15
`define SBT_AREA_LSB         11
`define SBT_WORD_ZERO        16'h0000
`define SBT_BYTE_ZERO        8'h00
`define SBT_ONE8             8'd1
`define SBT_ONE16            16'd1

`endif

// file: verilog/sbt_pkg.sv
package sbt_pkg;

  // Transfer sequencer states.
  typedef enum logic [2:0] {
    SBT_IDLE  = 3'b000,
    SBT_START = 3'b001,
    SBT_FETCH = 3'b010,
    SBT_LOAD  = 3'b011,
    SBT_FIRST = 3'b100,
    SBT_SECND = 3'b101,
    SBT_END   = 3'b110,
    SBT_DRAIN = 3'b111
  } sbt_state_t;

  // Instruction operands as latched from software.
  typedef struct packed {
    logic        indirect;
    logic [15:0] src;
    logic [15:0] count;
    logic [15:0] order;
  } sbt_instr_t;

  // Status word seen by software.
  typedef struct packed {
    logic busy;
    logic error;
    logic enable;
  } sbt_status_t;

endpackage

// file: test/sbt_chk_sva.sv
`timescale 1ns/1ps
// Port-level checks of the transmitter; it sees no internal state.
module sbt_chk (
  input wire logic        pclk,      // Clock.
  input wire logic        presetn,   // Reset, active low.
  input wire logic        psel,      // APB select.
  input wire logic        penable,   // APB enable.
  input wire logic        pwrite,    // APB direction.
  input wire logic [7:0]  paddr,     // APB address.
  input wire logic [31:0] prdata,    // APB read data.
  input wire logic        pready,    // APB ready.
  input wire logic        pslverr,   // APB error.
  input wire logic        mem_rd,    // Fetch strobe.
  input wire logic        tx_valid,  // Byte offered.
  input wire logic [7:0]  tx_data,   // Byte value.
  input wire logic        tx_ready,  // Byte taken.
  input wire logic        rx_accept, // Reception open.
  input wire logic        rx_flush   // Reception flush.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A fetch is followed by at least three quiet cycles: one word, two pushes.
  sequence s_fetch;
    mem_rd ##1 !mem_rd [*3];
  endsequence
  sequence s_held;
    tx_valid && $stable(tx_data);
  endsequence
  chk_ready_always:
    assert property (pready) else $error("Ready dropped.");
  chk_bad_addr:
    assert property (psel && penable && (paddr > 8'h1c || paddr[1:0] != 2'b00) |-> pslverr) else $error("No error.");
  chk_good_addr:
    assert property (psel && penable && paddr <= 8'h1c && paddr[1:0] == 2'b00 |-> !pslverr) else $error("Error.");
  chk_bad_reads_zero:
    assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0) else $error("Data on error.");
  chk_tx_byte_held:
    assert property (tx_valid && !tx_ready |=> s_held) else $error("Byte lost.");
  chk_fetch_spacing:
    assert property (mem_rd |-> s_fetch) else $error("Fetch too soon.");
  chk_rx_closed:
    assert property (mem_rd |-> !rx_accept) else $error("Reception open.");
  chk_flush_single:
    assert property (rx_flush |=> !rx_flush) else $error("Long flush.");
  chk_flush_after_tx:
    assert property (rx_flush |-> rx_accept && !$past(rx_accept)) else $error("Flush out of place.");
endmodule

bind sbt_top sbt_chk chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_rd(mem_rd),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_accept(rx_accept),
  .rx_flush(rx_flush)
);

// file: test/sbt_sink.sv
`timescale 1ns/1ps
// Serial device model that records every byte it takes.
module sbt_sink (
  input  wire logic       pclk,     // Clock.
  input  wire logic       presetn,  // Reset, active low.
  input  wire logic       slow,     // Stall every other cycle.
  input  wire logic       tx_valid, // Byte offered.
  input  wire logic [7:0] tx_data,  // Byte value.
  output logic            tx_ready  // Byte taken.
);
  logic [7:0] got [$];
  // A slow device toggles ready, so the block has to hold each byte.
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      tx_ready <= 1'b0;
    else
    begin
      if (tx_valid && tx_ready)
        got.push_back(tx_data);
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
`include "sbt_defs.svh"
// Drives the block over APB and checks the bytes the device receives.
module testbench;
  import sbt_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic msg_busy = 0, slow = 0, qerr;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [15:0] mem_addr, mem_rdata = 0;
  logic pready, pslverr, mem_rd, tx_valid, tx_ready, rx_accept, rx_flush;
  logic [7:0] tx_data;
  int failures = 0, tests_run = 0;
  int rx_cnt = 0, flush_cnt = 0, rx_base = 0, flush_base = 0;
  sbt_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .msg_busy(msg_busy),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_accept(rx_accept),
    .rx_flush(rx_flush));
  sbt_sink sink (.pclk(pclk), .presetn(presetn), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));
  always #2.5 pclk = ~pclk;
  // Memory answers a cycle after the strobe; otherwise junk so stale data shows.
  always @(posedge pclk)
  begin
    mem_rdata <= mem_rd ? {mem_addr[7:0] + 8'h40, mem_addr[7:0]} : ~mem_rdata;
    if (!rx_accept)
      rx_cnt <= rx_cnt + 1;
    if (rx_flush)
      flush_cnt <= flush_cnt + 1;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", nm, e, g);
      failures++;
    end
  endtask
  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    chk("pready", 32'h1, {31'h0, pready});
    q = prdata;
    qerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0, d});
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  // Loads the operands, fires the instruction and waits for busy to fall.
  task automatic blk(input logic [15:0] s, c, o, ctl, input bit dbl);
    int k;
    sink.got.delete();
    rx_base = rx_cnt;
    flush_base = flush_cnt;
    wr(`SBT_ADDR_SRC, s);
    wr(`SBT_ADDR_COUNT, c);
    wr(`SBT_ADDR_ORDER, o);
    wr(`SBT_ADDR_CTRL, ctl);
    if (dbl)
      wr(`SBT_ADDR_CTRL, ctl);
    k = 0;
    do
    begin
      apb(1'b0, `SBT_ADDR_STATUS, 32'h0);
      k++;
    end
    while (q[`SBT_STAT_BUSY] !== 1'b0 && k < 3000);
    chk("done", 32'h0, {31'h0, q[`SBT_STAT_BUSY]});
    repeat (3) @(posedge pclk);
  endtask
  // Expected stream: optional codes around the data bytes in the chosen order.
  task automatic want(input logic [15:0] s, input int n, input int o, input bit codes);
    logic [7:0] e [$];
    logic [15:0] w;
    if (codes)
      e.push_back(8'h02);
    for (int i = 0; i < n; i++)
    begin
      w = s + 16'(i / 2);
      e.push_back((i % 2 == o) ? w[7:0] + 8'h40 : w[7:0]);
    end
    if (codes)
      e.push_back(8'h0d);
    chk("count", 32'(e.size()), 32'(sink.got.size()));
    foreach (e[i])
      chk("byte", {24'h0, e[i]}, i < sink.got.size() ? {24'h0, sink.got[i]} : 32'hx);
  endtask
  task automatic fault(input logic [15:0] s, c, o, ctl, input logic [31:0] st);
    blk(s, c, o, ctl, 1'b0);
    chk("bytes", 32'h0, 32'(sink.got.size()));
    rd_chk("status", `SBT_ADDR_STATUS, st);
    wr(`SBT_ADDR_STATUS, 16'h0002);
    rd_chk("cleared", `SBT_ADDR_STATUS, st & 32'h1);
  endtask
  task automatic wrap_up;
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog well beyond the eight hundred or so cycles the sequence needs.
  initial
  begin
    #200us;
    failures++;
    wrap_up();
  end
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("status", `SBT_ADDR_STATUS, 32'h0);
    rd_chk("start", `SBT_ADDR_START_CODE, 32'h0);
    wr(`SBT_ADDR_PORT_MODE, 16'h0200);
    rd_chk("status", `SBT_ADDR_STATUS, 32'h1);
    wr(`SBT_ADDR_START_CODE, 16'h0102);
    wr(`SBT_ADDR_END_CODE, 16'h010d);
    rd_chk("start", `SBT_ADDR_START_CODE, 32'h0102);
    slow <= 1'b1;
    blk(16'h0010, 16'h0003, 16'h0000, 16'h0003, 1'b0);
    want(16'h0010, 3, 0, 1'b1);
    chk("rx_closed", 32'h1, {31'h0, rx_cnt != rx_base});
    chk("flushed", 32'h1, 32'(flush_cnt - flush_base));
    wr(`SBT_ADDR_START_CODE, 16'h0002);
    wr(`SBT_ADDR_END_CODE, 16'h000d);
    blk(16'h0020, 16'h0200, 16'h0001, 16'h0003, 1'b0);
    want(16'h0020, 200, 1, 1'b0);
    blk(16'h0010, 16'h0003, 16'h0000, 16'h0001, 1'b0);
    chk("idle_bytes", 32'h0, 32'(sink.got.size()));
    chk("idle_rx", 32'h0, 32'(rx_cnt - rx_base));
    chk("idle_flush", 32'h0, 32'(flush_cnt - flush_base));
    blk(16'h0040, 16'h0010, 16'h0000, 16'h0003, 1'b1);
    want(16'h0040, 10, 0, 1'b0);
    rd_chk("status", `SBT_ADDR_STATUS, 32'h3);
    wr(`SBT_ADDR_STATUS, 16'h0002);
    blk(16'h0048, 16'h0004, 16'h0000, 16'h0007, 1'b0);
    want(16'h0030, 4, 0, 1'b0);
    fault(16'h0010, 16'h0003, 16'h0002, 16'h0003, 32'h3);
    fault(16'h0010, 16'h0201, 16'h0000, 16'h0003, 32'h3);
    fault(16'h0010, 16'h001a, 16'h0000, 16'h0003, 32'h3);
    fault(16'h07ff, 16'h0004, 16'h0000, 16'h0003, 32'h3);
    fault(16'h00ab, 16'h0002, 16'h0000, 16'h0007, 32'h3);
    msg_busy <= 1'b1;
    rd_chk("status", `SBT_ADDR_STATUS, 32'h0);
    fault(16'h0010, 16'h0002, 16'h0000, 16'h0003, 32'h2);
    msg_busy <= 1'b0;
    rd_chk("status", `SBT_ADDR_STATUS, 32'h1);
    wr(`SBT_ADDR_PORT_MODE, 16'h0100);
    fault(16'h0010, 16'h0002, 16'h0000, 16'h0003, 32'h2);
    wr(`SBT_ADDR_PORT_MODE, 16'h0200);
    rd_chk("unmapped", 8'h20, 32'h0);
    chk("slverr", 32'h1, {31'h0, qerr});
    wrap_up();
  end
endmodule
